// ==== design/ilas_cfg_pkg.sv ====
// shared constants, mode table and field sums for the lane alignment parameter set
package ilas_cfg_pkg;
  localparam int MODE_W      = 5;
  localparam int KM1_W       = 5;
  localparam int DID_W       = 8;
  localparam int IDX_W       = 4;
  localparam int LANE_W      = 3;
  localparam int LANES_MAX   = 8;
  localparam int LINKS_MAX   = 2;
  localparam logic [3:0] CHKSUM_IDX = 4'hD;
  localparam logic [5:0] K_MAX      = 6'h20;
  // reset values of the configuration
  localparam logic [4:0] MODE_RST = 5'h00;
  localparam logic [4:0] KM1_RST  = 5'h1F;
  localparam logic [7:0] DID_RST  = 8'h00;
  localparam logic       SCR_RST  = 1'b0;
  // fields that never change
  localparam logic [3:0] ADJCNT_VAL    = 4'h0;
  localparam logic [3:0] BID_VAL       = 4'h0;
  localparam logic       ADJDIR_VAL    = 1'b0;
  localparam logic       PHADJ_VAL     = 1'b0;
  localparam logic [1:0] CS_ILAS_VAL   = 2'h0;
  localparam logic       HD_VAL        = 1'b0;
  localparam logic [4:0] CF_VAL        = 5'h00;
  localparam logic [2:0] JESDV_VAL     = 3'h1;
  localparam logic [2:0] SUBCLASSV_VAL = 3'h1;
  localparam logic [7:0] RES1_VAL      = 8'h00;
  localparam logic [7:0] RES2_VAL      = 8'h00;
  // serializer pll is bypassed when one bit per lane per clock
  localparam logic [4:0] R_X4_BYPASS   = 5'h04;

  typedef struct packed {
    logic       valid;
    logic [4:0] dec;
    logic       des;
    logic [1:0] links;
    logic [4:0] n;
    logic [1:0] cs;
    logic [4:0] np;
    logic [3:0] l;
    logic [3:0] m;
    logic [3:0] f;
    logic [3:0] s;
    logic [4:0] r_x4;
    logic [4:0] k_min;
    logic [1:0] k_step;
  } mode_type;

  function automatic mode_type mode_lookup(input logic [4:0] sel);
    mode_type t;
    case (sel)
      5'h00: t = '{1'b1,5'h01,1'b1,2'h2,5'h0C,2'h0,5'h0C,4'h4,4'h4,4'h8,4'h5,5'h10,5'h03,2'h1};
      5'h01: t = '{1'b1,5'h01,1'b1,2'h2,5'h0C,2'h0,5'h0C,4'h8,4'h8,4'h8,4'h5,5'h08,5'h03,2'h1};
      5'h02: t = '{1'b1,5'h01,1'b0,2'h2,5'h0C,2'h0,5'h0C,4'h4,4'h4,4'h8,4'h5,5'h10,5'h03,2'h1};
      5'h03: t = '{1'b1,5'h01,1'b0,2'h2,5'h0C,2'h0,5'h0C,4'h8,4'h8,4'h8,4'h5,5'h08,5'h03,2'h1};
      5'h04: t = '{1'b1,5'h01,1'b1,2'h2,5'h08,2'h0,5'h08,4'h2,4'h1,4'h1,4'h2,5'h14,5'h12,2'h2};
      5'h05: t = '{1'b1,5'h01,1'b1,2'h2,5'h08,2'h0,5'h08,4'h4,4'h1,4'h1,4'h4,5'h0A,5'h12,2'h2};
      5'h06: t = '{1'b1,5'h01,1'b0,2'h2,5'h08,2'h0,5'h08,4'h2,4'h1,4'h1,4'h2,5'h14,5'h12,2'h2};
      5'h07: t = '{1'b1,5'h01,1'b0,2'h2,5'h08,2'h0,5'h08,4'h4,4'h1,4'h1,4'h4,5'h0A,5'h12,2'h2};
      5'h09: t = '{1'b1,5'h02,1'b0,2'h2,5'h0F,2'h1,5'h10,4'h4,4'h1,4'h2,4'h4,5'h0A,5'h09,2'h1};
      5'h0A: t = '{1'b1,5'h04,1'b0,2'h2,5'h0F,2'h1,5'h10,4'h2,4'h2,4'h2,4'h1,5'h14,5'h09,2'h1};
      5'h0B: t = '{1'b1,5'h04,1'b0,2'h2,5'h0F,2'h1,5'h10,4'h4,4'h2,4'h2,4'h2,5'h0A,5'h09,2'h1};
      5'h0C: t = '{1'b1,5'h04,1'b0,2'h2,5'h0C,2'h0,5'h0C,4'h8,4'h8,4'h8,4'h5,5'h04,5'h03,2'h1};
      5'h0D: t = '{1'b1,5'h08,1'b0,2'h2,5'h0F,2'h1,5'h10,4'h1,4'h2,4'h4,4'h1,5'h14,5'h05,2'h1};
      5'h0E: t = '{1'b1,5'h08,1'b0,2'h2,5'h0F,2'h1,5'h10,4'h2,4'h2,4'h2,4'h1,5'h0A,5'h09,2'h1};
      5'h0F: t = '{1'b1,5'h10,1'b0,2'h1,5'h0F,2'h1,5'h10,4'h1,4'h4,4'h8,4'h1,5'h14,5'h03,2'h1};
      5'h10: t = '{1'b1,5'h10,1'b0,2'h2,5'h0F,2'h1,5'h10,4'h1,4'h2,4'h4,4'h1,5'h0A,5'h05,2'h1};
      5'h11: t = '{1'b1,5'h01,1'b1,2'h2,5'h08,2'h0,5'h08,4'h8,4'h1,4'h1,4'h8,5'h05,5'h12,2'h2};
      5'h12: t = '{1'b1,5'h01,1'b0,2'h2,5'h08,2'h0,5'h08,4'h8,4'h1,4'h1,4'h8,5'h05,5'h12,2'h2};
      default: t = '0;
    endcase
    return t;
  endfunction

  // K is allowed when within range and on the mode's step
  function automatic logic k_allowed(input mode_type t, input logic [4:0] km1);
    logic [5:0] k;
    logic [5:0] off;
    k   = {1'b0, km1} + 6'h01;
    off = k - {1'b0, t.k_min};
    return t.valid && (k >= {1'b0, t.k_min}) && (k <= K_MAX)
           && ((t.k_step != 2'h2) || !off[0]);
  endfunction

  // sum of the parameter fields packed in one octet
  function automatic logic [7:0] field_sum(input logic [3:0] idx, input logic [7:0] o);
    case (idx)
      4'h1:    return 8'(o[7:4]) + 8'(o[3:0]);
      4'h2:    return 8'(o[6]) + 8'(o[5]) + 8'(o[4:0]);
      4'h3:    return 8'(o[7]) + 8'(o[4:0]);
      4'h5:    return 8'(o[4:0]);
      4'h7:    return 8'(o[7:6]) + 8'(o[4:0]);
      4'h8,
      4'h9:    return 8'(o[7:5]) + 8'(o[4:0]);
      4'hA:    return 8'(o[7]) + 8'(o[4:0]);
      4'h0,
      4'h4,
      4'h6,
      4'hB,
      4'hC:    return o;
      default: return 8'h00;
    endcase
  endfunction
endpackage

// ==== design/ilas_link_if.sv ====
// configuration and alignment parameter carrier between converter and receiver
`timescale 1ns/1ps
`default_nettype none
interface ilas_link_if;
  logic        cfg_load;
  logic [4:0]  link_mode_select;
  logic [4:0]  frames_per_multiframe_minus_one;
  logic [7:0]  did;
  logic        scr_en;
  logic        sync_req;
  logic        octet_valid;
  logic [7:0]  octet;
  logic [3:0]  octet_index;
  logic        octet_link;
  logic [2:0]  octet_lane;
  logic [15:0] lane_enable;

  modport dev (
    input  cfg_load, link_mode_select, frames_per_multiframe_minus_one, did, scr_en,
    input  sync_req,
    output octet_valid, octet, octet_index, octet_link, octet_lane, lane_enable
  );
  modport host (
    output cfg_load, link_mode_select, frames_per_multiframe_minus_one, did, scr_en,
    output sync_req,
    input  octet_valid, octet, octet_index, octet_link, octet_lane, lane_enable
  );
endinterface
`default_nettype wire

// ==== design/ilas_receiver_cfg.sv ====
// receiver end: configures the converter, checks the alignment parameter set
`timescale 1ns/1ps
`default_nettype none
module ilas_receiver_cfg (
  input  wire logic        i_core_clk,
  input  wire logic        i_sys_rst,
  ilas_link_if.host        link,
  input  wire logic [4:0]  i_link_mode_select,
  input  wire logic [4:0]  i_frames_per_multiframe_minus_one,
  input  wire logic [7:0]  i_did,
  input  wire logic        i_scr_en,
  input  wire logic        i_apply,
  input  wire logic        i_sync_req,
  output logic             o_cfg_rejected,
  output logic             o_rx_done,
  output logic             o_chk_error,
  output logic [4:0]       o_lanes_seen
);
  ilas_cfg_pkg::mode_type req_mode;
  ilas_cfg_pkg::mode_type act_mode;
  logic       load;
  logic [4:0] mode_q;
  logic [4:0] km1_q;
  logic [7:0] did_q;
  logic       scr_q;
  logic       rej;
  logic [7:0] acc;
  logic       err;
  logic [4:0] lanes;
  logic       done;
  logic       next_load;
  logic [4:0] next_mode_q;
  logic [4:0] next_km1_q;
  logic [7:0] next_did_q;
  logic       next_scr_q;
  logic       next_rej;
  logic [7:0] next_acc;
  logic       next_err;
  logic [4:0] next_lanes;
  logic       next_done;
  logic [4:0] expect_lanes;

  assign req_mode     = ilas_cfg_pkg::mode_lookup(i_link_mode_select);
  assign act_mode     = ilas_cfg_pkg::mode_lookup(mode_q);
  assign expect_lanes = 5'(act_mode.l) * 5'(act_mode.links);

  always_comb begin
    next_load   = 1'b0;
    next_mode_q = mode_q;
    next_km1_q  = km1_q;
    next_did_q  = did_q;
    next_scr_q  = scr_q;
    next_rej    = rej;
    next_acc    = acc;
    next_err    = err;
    next_lanes  = lanes;
    next_done   = 1'b0;
    if (i_apply) begin
      // only listed modes with an allowed K leave this end
      if (ilas_cfg_pkg::k_allowed(req_mode, i_frames_per_multiframe_minus_one)) begin
        next_load   = 1'b1;
        next_mode_q = i_link_mode_select;
        next_km1_q  = i_frames_per_multiframe_minus_one;
        next_did_q  = i_did;
        next_scr_q  = i_scr_en;
        next_rej    = 1'b0;
      end else begin
        next_rej = 1'b1;
      end
    end
    if (link.octet_valid) begin
      if (link.octet_index == 4'h0) begin
        next_acc = ilas_cfg_pkg::field_sum(link.octet_index, link.octet);
        if (!link.octet_link && link.octet_lane == 3'h0) begin
          next_err   = 1'b0;
          next_lanes = 5'h00;
        end
      end else if (link.octet_index < ilas_cfg_pkg::CHKSUM_IDX) begin
        next_acc = acc + ilas_cfg_pkg::field_sum(link.octet_index, link.octet);
      end else begin
        if (link.octet != acc) begin
          next_err = 1'b1;
        end
        next_lanes = lanes + 5'h01;
        next_done  = (lanes + 5'h01) == expect_lanes;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      load   <= 1'b0;
      mode_q <= ilas_cfg_pkg::MODE_RST;
      km1_q  <= ilas_cfg_pkg::KM1_RST;
      did_q  <= ilas_cfg_pkg::DID_RST;
      scr_q  <= ilas_cfg_pkg::SCR_RST;
      rej    <= 1'b0;
      acc    <= 8'h00;
      err    <= 1'b0;
      lanes  <= 5'h00;
      done   <= 1'b0;
    end else begin
      load   <= next_load;
      mode_q <= next_mode_q;
      km1_q  <= next_km1_q;
      did_q  <= next_did_q;
      scr_q  <= next_scr_q;
      rej    <= next_rej;
      acc    <= next_acc;
      err    <= next_err;
      lanes  <= next_lanes;
      done   <= next_done;
    end
  end

  assign link.cfg_load                        = load;
  assign link.link_mode_select                = mode_q;
  assign link.frames_per_multiframe_minus_one = km1_q;
  assign link.did                             = did_q;
  assign link.scr_en                          = scr_q;
  assign link.sync_req                        = i_sync_req;
  assign o_cfg_rejected = rej;
  assign o_rx_done      = done;
  assign o_chk_error    = err;
  assign o_lanes_seen   = lanes;
endmodule
`default_nettype wire

// ==== design/jesd_mode_ilas_param_gen.sv ====
// converter end: mode decode and lane alignment parameter generation
`timescale 1ns/1ps
`default_nettype none
// Function
// - one mode selector derives every link format parameter
// - interleave flag one single-channel, zero dual-channel
// - line rate factor sets pll multiply or bypass
// - host writes allowed K, device uses it
// - full parameter set sent on every lane
// - fixed fields zero, versions one
// - CS always reported zero
// - HD reported zero, no split samples
// - programmed DID sent as link identifier
// - scrambling choice reported in SCR
// - checksum is field sum modulo 256
// - M taken from mode for packing
// - lane identifier from lane position
// - N prime reported separately from N
// - host picks only listed modes
// - lowest lanes used, upper lanes powered down
// - second link reports DID plus one
module jesd_mode_ilas_param_gen #(
  parameter int LANES_PER_LINK = 8,
  parameter int LINK_COUNT     = 2
) (
  input  wire logic       i_core_clk,
  input  wire logic       i_sys_rst,
  ilas_link_if.dev        link,
  output logic [4:0]      o_decimation,
  output logic            o_interleave,
  output logic [1:0]      o_link_count,
  output logic [4:0]      o_line_rate_x4,
  output logic            o_serdes_pll_bypass,
  output logic [5:0]      o_multiframe_frames,
  output logic            o_mode_valid,
  output logic            o_busy
);
  if (LANES_PER_LINK != ilas_cfg_pkg::LANES_MAX || LINK_COUNT != ilas_cfg_pkg::LINKS_MAX) begin
    $error("lane and link counts are fixed by the mode table");
  end

  typedef enum {ST_IDLE, ST_SEND} state_type;

  state_type              state;
  state_type              next_state;
  ilas_cfg_pkg::mode_type cfg;
  ilas_cfg_pkg::mode_type next_cfg;
  logic [4:0]  mode_sel;
  logic [4:0]  km1;
  logic [7:0]  did;
  logic        scr;
  logic        sync_prev;
  logic        lnk;
  logic [2:0]  lane;
  logic [3:0]  idx;
  logic        oct_valid;
  logic [7:0]  oct;
  logic [3:0]  oct_idx;
  logic        oct_link;
  logic [2:0]  oct_lane;
  logic [15:0] lane_en;
  logic [4:0]  next_mode_sel;
  logic [4:0]  next_km1;
  logic [7:0]  next_did;
  logic        next_scr;
  logic        next_lnk;
  logic [2:0]  next_lane;
  logic [3:0]  next_idx;
  logic        next_oct_valid;
  logic [7:0]  next_oct;
  logic [3:0]  next_oct_idx;
  logic        next_oct_link;
  logic [2:0]  next_oct_lane;
  logic [15:0] next_lane_en;
  logic        next_sync_prev;
  logic [7:0]  eff_did;
  logic [7:0]  chk;
  logic        last_lane;
  logic        last_link;

  // one octet of the parameter set for the current lane
  function automatic logic [7:0] build_octet(
    input ilas_cfg_pkg::mode_type c,
    input logic [3:0] i,
    input logic [7:0] d,
    input logic [2:0] lid,
    input logic       s,
    input logic [4:0] k1
  );
    case (i)
      4'h0:    return d;
      4'h1:    return {ilas_cfg_pkg::ADJCNT_VAL, ilas_cfg_pkg::BID_VAL};
      4'h2:    return {1'b0, ilas_cfg_pkg::ADJDIR_VAL, ilas_cfg_pkg::PHADJ_VAL, 2'h0, lid};
      4'h3:    return {s, 3'h0, c.l - 4'h1};
      4'h4:    return {4'h0, c.f - 4'h1};
      4'h5:    return {3'h0, k1};
      4'h6:    return {4'h0, c.m - 4'h1};
      4'h7:    return {ilas_cfg_pkg::CS_ILAS_VAL, 1'b0, c.n - 5'h01};
      4'h8:    return {ilas_cfg_pkg::SUBCLASSV_VAL, c.np - 5'h01};
      4'h9:    return {ilas_cfg_pkg::JESDV_VAL, 1'b0, c.s - 4'h1};
      4'hA:    return {ilas_cfg_pkg::HD_VAL, 2'h0, ilas_cfg_pkg::CF_VAL};
      4'hB:    return ilas_cfg_pkg::RES1_VAL;
      4'hC:    return ilas_cfg_pkg::RES2_VAL;
      default: return 8'h00;
    endcase
  endfunction

  assign eff_did   = did + {7'h00, lnk};
  assign last_lane = ({1'b0, lane} == cfg.l - 4'h1);
  assign last_link = ({1'b0, lnk} == cfg.links - 2'h1);

  always_comb begin
    chk = 8'h00;
    // wraps naturally at eight bits, giving the modulo 256 sum
    for (int i = 0; i < int'(ilas_cfg_pkg::CHKSUM_IDX); i++) begin
      chk = chk + ilas_cfg_pkg::field_sum(4'(i), build_octet(cfg, 4'(i), eff_did, lane, scr, km1));
    end
  end

  always_comb begin
    next_state     = state;
    next_mode_sel  = mode_sel;
    next_km1       = km1;
    next_did       = did;
    next_scr       = scr;
    next_lnk       = lnk;
    next_lane      = lane;
    next_idx       = idx;
    next_oct_valid = 1'b0;
    next_oct       = oct;
    next_oct_idx   = oct_idx;
    next_oct_link  = oct_link;
    next_oct_lane  = oct_lane;
    next_sync_prev = link.sync_req;
    // whole mode follows from the selector alone
    next_cfg       = ilas_cfg_pkg::mode_lookup(mode_sel);
    for (int b = 0; b < LANES_PER_LINK * LINK_COUNT; b++) begin
      // lowest lanes of each used link stay on
      next_lane_en[b] = next_cfg.valid && ((b / LANES_PER_LINK) < int'(next_cfg.links))
                        && ((b % LANES_PER_LINK) < int'(next_cfg.l));
    end
    case (state)
      ST_IDLE: begin
        // changing the set mid-sequence would corrupt the checksum
        if (link.cfg_load) begin
          next_mode_sel = link.link_mode_select;
          next_km1      = link.frames_per_multiframe_minus_one;
          next_did      = link.did;
          next_scr      = link.scr_en;
        end else if (link.sync_req && !sync_prev && cfg.valid) begin
          next_state = ST_SEND;
          next_lnk   = 1'b0;
          next_lane  = 3'h0;
          next_idx   = 4'h0;
        end
      end
      ST_SEND: begin
        next_oct_valid = 1'b1;
        next_oct       = (idx == ilas_cfg_pkg::CHKSUM_IDX) ? chk
                         : build_octet(cfg, idx, eff_did, lane, scr, km1);
        next_oct_idx   = idx;
        next_oct_link  = lnk;
        next_oct_lane  = lane;
        next_idx       = idx + 4'h1;
        if (idx == ilas_cfg_pkg::CHKSUM_IDX) begin
          next_idx = 4'h0;
          if (!last_lane) begin
            next_lane = lane + 3'h1;
          end else if (!last_link) begin
            next_lane = 3'h0;
            next_lnk  = 1'b1;
          end else begin
            next_state = ST_IDLE;
          end
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      state     <= ST_IDLE;
      cfg       <= '0;
      mode_sel  <= ilas_cfg_pkg::MODE_RST;
      km1       <= ilas_cfg_pkg::KM1_RST;
      did       <= ilas_cfg_pkg::DID_RST;
      scr       <= ilas_cfg_pkg::SCR_RST;
      sync_prev <= 1'b0;
      lnk       <= 1'b0;
      lane      <= 3'h0;
      idx       <= 4'h0;
      oct_valid <= 1'b0;
      oct       <= 8'h00;
      oct_idx   <= 4'h0;
      oct_link  <= 1'b0;
      oct_lane  <= 3'h0;
      lane_en   <= 16'h0000;
    end else begin
      state     <= next_state;
      cfg       <= next_cfg;
      mode_sel  <= next_mode_sel;
      km1       <= next_km1;
      did       <= next_did;
      scr       <= next_scr;
      sync_prev <= next_sync_prev;
      lnk       <= next_lnk;
      lane      <= next_lane;
      idx       <= next_idx;
      oct_valid <= next_oct_valid;
      oct       <= next_oct;
      oct_idx   <= next_oct_idx;
      oct_link  <= next_oct_link;
      oct_lane  <= next_oct_lane;
      lane_en   <= next_lane_en;
    end
  end

  assign link.octet_valid = oct_valid;
  assign link.octet       = oct;
  assign link.octet_index = oct_idx;
  assign link.octet_link  = oct_link;
  assign link.octet_lane  = oct_lane;
  assign link.lane_enable = lane_en;
  assign o_decimation        = cfg.dec;
  assign o_interleave        = cfg.des;
  assign o_link_count        = cfg.links;
  assign o_line_rate_x4      = cfg.r_x4;
  assign o_serdes_pll_bypass = cfg.valid && (cfg.r_x4 == ilas_cfg_pkg::R_X4_BYPASS);
  assign o_multiframe_frames = {1'b0, km1} + 6'h01;
  assign o_mode_valid        = cfg.valid;
  assign o_busy              = (state == ST_SEND);
endmodule
`default_nettype wire

// ==== testbench/ilas_link_sva.sv ====
// concurrent checks on the alignment parameter carrier between both ends
`timescale 1ns/1ps
`default_nettype none
module ilas_link_sva (
  input wire logic        i_core_clk,
  input wire logic        i_sys_rst,
  input wire logic        cfg_load,
  input wire logic [4:0]  link_mode_select,
  input wire logic [4:0]  frames_per_multiframe_minus_one,
  input wire logic [7:0]  did,
  input wire logic        scr_en,
  input wire logic        sync_req,
  input wire logic        octet_valid,
  input wire logic [7:0]  octet,
  input wire logic [3:0]  octet_index,
  input wire logic        octet_link,
  input wire logic [2:0]  octet_lane,
  input wire logic [15:0] lane_enable
);
  logic        act;
  logic        next_act;
  logic        mode_ok;
  logic        next_mode_ok;
  logic        sync_q;
  logic        rst_q;
  logic        start;
  logic        last;
  logic [16:0] le_x;
  logic [4:0]  pos;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  // mirrors the device idle state so a refused sync edge is not mistaken for a start
  always_comb begin
    le_x = {1'b0, lane_enable};
    pos = {1'b0, octet_link, octet_lane} + 5'h01;
    last = octet_valid && octet_index == 4'hD && !le_x[pos] && !(!octet_link && lane_enable[8]);
    start = sync_req && !sync_q && !act && !cfg_load && mode_ok;
    next_act = start || (act && !last);
    next_mode_ok = rst_q ? 1'b1 : mode_ok;
    if (cfg_load && !act) begin
      next_mode_ok = link_mode_select != 5'h08 && link_mode_select <= 5'h12;
    end
  end
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      act <= 1'b0;
      mode_ok <= 1'b0;
      sync_q <= 1'b0;
      rst_q <= 1'b1;
    end else begin
      act <= next_act;
      mode_ok <= next_mode_ok;
      sync_q <= sync_req;
      rst_q <= 1'b0;
    end
  end
  sequence s_first_octet;
    octet_valid && octet_index == 4'h0 && !octet_link && octet_lane == 3'h0;
  endsequence
  chk_pass_start: assert property (start |-> ##1 !octet_valid ##1 s_first_octet)
    else $error("pass did not open two cycles after sync edge");
  chk_no_stray: assert property (!act |-> !octet_valid)
    else $error("octet outside a pass");
  chk_stream_gapless: assert property (act && octet_valid && !last |=> octet_valid)
    else $error("gap inside a pass");
  chk_index_step: assert property (octet_valid && octet_index != 4'hD |=> octet_valid
    && octet_index == $past(octet_index) + 4'h1 && $stable(octet_lane) && $stable(octet_link))
    else $error("octet index did not step");
  chk_lane_order: assert property (octet_valid && octet_index == 4'hD && !last |=>
    octet_index == 4'h0 && {1'b0, octet_link, octet_lane} == (le_x[$past(pos)] ? $past(pos) : 5'h08))
    else $error("wrong next lane");
  chk_zero_fields: assert property (octet_valid && octet_index inside {4'h1, 4'hA, 4'hB, 4'hC}
    |-> octet == 8'h00)
    else $error("fixed field not zero");
  chk_cs_zero: assert property (octet_valid && octet_index == 4'h7 |-> octet[7:6] == 2'h0)
    else $error("control bits reported");
  chk_version_ones: assert property (octet_valid && octet_index inside {4'h8, 4'h9}
    |-> octet[7:5] == 3'h1)
    else $error("version field wrong");
  chk_lane_ident: assert property (octet_valid && octet_index == 4'h2
    |-> octet == {5'h00, octet_lane})
    else $error("lane identifier wrong");
  chk_did_link: assert property (octet_valid && octet_index == 4'h0
    |-> octet == did + 8'(octet_link))
    else $error("link identifier wrong");
  chk_scr_report: assert property (octet_valid && octet_index == 4'h3 |-> octet[7] == scr_en)
    else $error("scrambling flag wrong");
  chk_k_field: assert property (octet_valid && octet_index == 4'h5
    |-> octet == {3'h0, frames_per_multiframe_minus_one})
    else $error("multiframe field wrong");
  chk_lanes_low: assert property (((lane_enable[7:0] & (lane_enable[7:0] + 8'h01)) == 8'h00)
    && ((lane_enable[15:8] & (lane_enable[15:8] + 8'h01)) == 8'h00))
    else $error("enabled lanes not lowest");
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
// bench: receiver end configures the converter end over all modes and checks each pass
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // one hex digit per mode (two in R_TAB), mode 0 leftmost
  localparam logic [75:0]  D_TAB  = 76'h0000000001222334400;
  localparam logic [75:0]  S1_TAB = 76'h1100110000000000010;
  localparam logic [75:0]  LK_TAB = 76'h2222222202222221222;
  localparam logic [75:0]  N_TAB  = 76'hCCCC88880FFFCFFFF88;
  localparam logic [75:0]  L_TAB  = 76'h4848242404248121188;
  localparam logic [75:0]  M_TAB  = 76'h4848111101228224211;
  localparam logic [75:0]  F_TAB  = 76'h8888111102228428411;
  localparam logic [75:0]  S_TAB  = 76'h5555242404125111188;
  localparam logic [75:0]  K_TAB  = 76'h3333000009993593500;
  localparam logic [151:0] R_TAB  = 152'h10081008140A140A000A140A04140A140A0505;
  logic        core_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [4:0]  mode_r = 5'h00;
  logic [4:0]  km1_r = 5'h1F;
  logic [7:0]  did_r = 8'h00;
  logic        scr_r = 1'b0;
  logic        apply = 1'b0;
  logic        sync = 1'b0;
  logic [4:0]  dec, rx4, seen;
  logic        ilv, byp, mval, busy, rej, done, cerr;
  logic [1:0]  lnk;
  logic [5:0]  kf;
  logic [15:0] pos_s;
  logic [7:0]  e_did;
  logic        e_scr;
  int          err_total = 0;
  int          total_checks = 0;
  int          e_mode, e_km1, ei, ej, ek, octs;

  ilas_link_if link ();
  jesd_mode_ilas_param_gen i_jesd_mode_ilas_param_gen (.i_core_clk(core_clk), .i_sys_rst(sys_rst),
    .link(link), .o_decimation(dec), .o_interleave(ilv), .o_link_count(lnk), .o_line_rate_x4(rx4),
    .o_serdes_pll_bypass(byp), .o_multiframe_frames(kf), .o_mode_valid(mval), .o_busy(busy));
  ilas_receiver_cfg i_ilas_receiver_cfg (.i_core_clk(core_clk), .i_sys_rst(sys_rst), .link(link),
    .i_link_mode_select(mode_r), .i_frames_per_multiframe_minus_one(km1_r), .i_did(did_r),
    .i_scr_en(scr_r), .i_apply(apply), .i_sync_req(sync), .o_cfg_rejected(rej),
    .o_rx_done(done), .o_chk_error(cerr), .o_lanes_seen(seen));
  ilas_link_sva i_ilas_link_sva (.i_core_clk(core_clk), .i_sys_rst(sys_rst),
    .cfg_load(link.cfg_load), .link_mode_select(link.link_mode_select),
    .frames_per_multiframe_minus_one(link.frames_per_multiframe_minus_one), .did(link.did),
    .scr_en(link.scr_en), .sync_req(link.sync_req), .octet_valid(link.octet_valid),
    .octet(link.octet), .octet_index(link.octet_index), .octet_link(link.octet_link),
    .octet_lane(link.octet_lane), .lane_enable(link.lane_enable));

  always #5 core_clk = ~core_clk;

  function automatic logic [3:0] nib(input logic [75:0] t, input int m);
    return (m > 18) ? 4'h0 : t[4 * (18 - m) +: 4];
  endfunction
  function automatic int kmin(input int m);
    return (nib(N_TAB, m) == 4'h8) ? 18 : int'(nib(K_TAB, m));
  endfunction
  function automatic logic [7:0] exp_oct(input int i, input int k, input int j);
    int l, f, m, n, s, cs;
    logic [7:0] o [14];
    l = nib(L_TAB, e_mode);
    f = nib(F_TAB, e_mode);
    m = nib(M_TAB, e_mode);
    n = nib(N_TAB, e_mode);
    s = nib(S_TAB, e_mode);
    cs = (n == 15) ? 1 : 0;
    o = '{e_did + 8'(k), 8'h00, 8'(j), {e_scr, 2'b00, 5'(l - 1)}, 8'(f - 1), 8'(e_km1), 8'(m - 1),
          8'(n - 1), 8'(32 + n + cs - 1), 8'(32 + s - 1), 8'h00, 8'h00, 8'h00, 8'h00};
    o[13] = e_did + 8'(k + j + e_scr + l + f + m + n + n + cs + s - 4 + e_km1);
    return o[i];
  endfunction

  task automatic check(input logic [15:0] seen_v, input logic [15:0] exp_v);
    total_checks++;
    if (seen_v !== exp_v) begin
      err_total++;
      $display("mismatch at %0t ns: got %h want %h", $time, seen_v, exp_v);
    end
  endtask
  task automatic give_verdict();
    if (err_total == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // sampled at the falling edge so registered outputs have settled
  always @(negedge core_clk) begin
    if (link.octet_valid === 1'b1) begin
      pos_s = {4'h0, link.octet_index, 3'h0, link.octet_link, 1'b0, link.octet_lane};
      check(pos_s, 16'(ei * 256 + ek * 16 + ej));
      check(16'(link.octet), 16'(exp_oct(ei, ek, ej)));
      octs++;
      ei++;
      if (ei == 14) begin
        ei = 0;
        ej++;
      end
      if (ej == nib(L_TAB, e_mode)) begin
        ej = 0;
        ek++;
      end
      if (ek == nib(LK_TAB, e_mode)) begin
        ek = 0;
      end
    end
  end

  task automatic check_derived();
    int r;
    int l;
    r = int'(R_TAB[8 * (18 - e_mode) +: 8]);
    l = (1 << nib(L_TAB, e_mode)) - 1;
    check(16'(dec), 16'(1 << nib(D_TAB, e_mode)));
    check(16'(ilv), 16'(nib(S1_TAB, e_mode)));
    check(16'(lnk), 16'(nib(LK_TAB, e_mode)));
    check(16'(rx4), 16'(r));
    check(16'(byp), 16'(r == 4));
    check(16'(kf), 16'(e_km1 + 1));
    check(16'(mval), 16'h0001);
    check(link.lane_enable, 16'(nib(LK_TAB, e_mode) == 2 ? l * 257 : l));
  endtask
  task automatic run_pass();
    int n;
    int lanes;
    int o0;
    lanes = nib(L_TAB, e_mode) * nib(LK_TAB, e_mode);
    o0 = octs;
    n = 0;
    @(posedge core_clk);
    sync <= 1'b1;
    do begin
      @(negedge core_clk);
      n++;
      if (n == 2) check(16'(busy), 16'h0001);
    end while (done !== 1'b1 && n < 300);
    check(16'(done), 16'h0001);
    check(16'(busy), 16'h0000);
    @(posedge core_clk);
    sync <= 1'b0;
    check(16'(octs - o0), 16'(14 * lanes));
    check(16'(seen), 16'(lanes));
    check(16'(cerr), 16'h0000);
  endtask
  task automatic trial(input int md, input int k1, input logic [7:0] dv);
    logic ok;
    logic sc;
    sc = 1'($urandom);
    ok = md <= 18 && md != 8 && k1 + 1 >= kmin(md) && (kmin(md) != 18 || k1 % 2 == 1);
    @(posedge core_clk);
    mode_r <= 5'(md);
    km1_r <= 5'(k1);
    did_r <= dv;
    scr_r <= sc;
    apply <= 1'b1;
    @(posedge core_clk);
    apply <= 1'b0;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    check(16'(rej), 16'(!ok));
    if (ok) begin
      e_mode = md;
      e_km1 = k1;
      e_did = dv;
      e_scr = sc;
    end
    // a refused apply must leave the previous configuration in force
    check_derived();
    if (ok) run_pass();
  endtask

  initial begin
    int cm [7] = '{4, 4, 0, 20, 4, 31, 9};
    int ck [7] = '{16, 18, 1, 2, 19, 3, 31};
    void'($urandom(42));
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(negedge core_clk);
    check(16'(kf), 16'h0020);
    check(16'(mval), 16'h0000);
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    e_mode = 0;
    e_km1 = 31;
    e_did = 8'h00;
    e_scr = 1'b0;
    check_derived();
    for (int md = 0; md < 19; md++) trial(md, kmin(md) - 1, md == 1 ? 8'hFF : 8'($urandom));
    foreach (cm[c]) trial(cm[c], ck[c], 8'h5A);
    repeat (12) trial(int'($urandom % 21), int'($urandom % 32), 8'($urandom));
    give_verdict();
  end
  initial begin
    #500000;
    err_total++;
    give_verdict();
  end
endmodule
`default_nettype wire
